// file: src/plrg_ctrl.sv
// misc control: phase loop, rate generator, loop/echo, request pin, event enables
`timescale 1ns/1ps
module plrg_ctrl (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic chan_reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // line pins and channel state
    input wire plrg_pkg::plrg_pins_t pins,
    input wire plrg_pkg::plrg_chan_t chan,
    // results
    output plrg_pkg::plrg_out_t outs
);
    import plrg_pkg::*;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        hit = (a == r);
    endfunction

    typedef struct packed {
        logic [2:0] pin_s1;
        logic [2:0] pin_s2;
        logic [1:0] ck_s1;
        logic [1:0] ck_s2;
        logic [1:0] ck_d;
        logic [5:0] ev_s1;
        logic [5:0] ev_s2;
        logic [5:0] ev_d;
        logic [7:0] misc;
        logic [7:0] evt;
        logic [15:0] tc;
        logic pl_fm;
        logic pl_src_rg;
        plrg_plst_t pl_st;
        logic [5:0] pl_cnt;
        logic pl_out;
        logic pl_win;
        logic pl_seen;
        logic pl_odd;
        logic miss1;
        logic miss2;
        logic rxd_d;
        logic [15:0] rg_cnt;
        logic [1:0] rg_lag;
        logic rg_out;
        logic rg_zero;
        logic ext_pend;
        logic req_n;
        logic [2:0] req_hold;
        logic [31:0] rdata;
        logic rdy;
        logic err;
        plrg_out_t o;
    } plrg_state_t;

    plrg_state_t s_q, s_d;

    logic acc, wr, tx_sel;
    logic [2:0] pin_now;
    logic [1:0] ck_now;
    logic [5:0] ev_now;
    logic [5:0] ev_en;
    logic [5:0] ev_chg;
    logic pl_tick, rg_tick, rxd_edge, pin_rise, fire;
    logic [5:0] div, half;
    plrg_cmd_t cmd;

    assign pin_now = {pins.rxd, pins.cts_n, pins.dcd_n};
    assign ck_now = {pins.clk_pin, pins.xtal_clk};
    // order: brk, und, cts, sync/hunt, dcd, zero count
    assign ev_en = {s_q.evt[PLRG_E_BRK], s_q.evt[PLRG_E_UND], s_q.evt[PLRG_E_CTS],
                    s_q.evt[PLRG_E_SYNC], s_q.evt[PLRG_E_DCD], s_q.evt[PLRG_E_ZC]};

    always_comb begin
        s_d = s_q;
        acc = psel && penable;
        wr = acc && pwrite;
        cmd = plrg_cmd_t'(pwdata[7:5]);
        ////////////////////////////////////////////////////////////////////////
        // pin and clock synchronisers; first stage feeds only the second
        s_d.pin_s1 = pin_now;
        s_d.pin_s2 = s_q.pin_s1;
        s_d.ck_s1 = ck_now;
        s_d.ck_s2 = s_q.ck_s1;
        s_d.ck_d = s_q.ck_s2;
        // crystal_select picks crystal over pin
        tx_sel = chan.crystal_select ? s_q.ck_s2[0] : s_q.ck_s2[1];
        pin_rise = tx_sel && !(chan.crystal_select ? s_q.ck_d[0] : s_q.ck_d[1]);
        ////////////////////////////////////////////////////////////////////////
        // apb: zero wait states, unmapped reads zero with error
        s_d.rdy = psel && !s_q.rdy;
        s_d.err = 1'b0;
        s_d.rdata = '0;
        if (psel && !penable) begin
            s_d.rdy = 1'b1;
            s_d.err = !(hit(paddr, PLRG_ADDR_MISC) || hit(paddr, PLRG_ADDR_EVT) ||
                        hit(paddr, PLRG_ADDR_TC) || hit(paddr, PLRG_ADDR_STAT));
            if (hit(paddr, PLRG_ADDR_MISC))
                s_d.rdata = {24'h00_0000, s_q.misc};
            else if (hit(paddr, PLRG_ADDR_EVT))
                s_d.rdata = {24'h00_0000, s_q.evt};
            else if (hit(paddr, PLRG_ADDR_TC))
                s_d.rdata = {16'h0000, s_q.tc};
            else if (hit(paddr, PLRG_ADDR_STAT))
                s_d.rdata = {24'h00_0000, s_q.pl_st, s_q.pl_fm, s_q.pl_src_rg,
                             s_q.miss2, s_q.miss1, s_q.ext_pend, s_q.rg_zero};
        end
        ////////////////////////////////////////////////////////////////////////
        // phase loop clock source: rate generator or pin/crystal
        pl_tick = s_q.pl_src_rg ? (s_q.rg_out && !s_q.o.rg_out)
                                : pin_rise;
        div = s_q.pl_fm ? PLRG_FM_DIV : PLRG_NRZI_DIV;
        half = s_q.pl_fm ? PLRG_FM_HALF : PLRG_NRZI_HALF;
        s_d.rxd_d = s_q.pin_s2[2];
        rxd_edge = s_q.pin_s2[2] ^ s_q.rxd_d;
        case (s_q.pl_st)
            PLRG_PL_OFF: begin
                s_d.pl_out = !s_q.pl_fm;
            end
            PLRG_PL_SEARCH: begin
                s_d.pl_out = !s_q.pl_fm;
                if (rxd_edge) begin
                    // first edge: data edge in nrzi, clock edge in fm
                    s_d.pl_st = PLRG_PL_TRACK;
                    s_d.pl_cnt = '0;
                    s_d.pl_seen = 1'b0;
                    s_d.pl_odd = 1'b0;
                end
            end
            PLRG_PL_TRACK: begin
                if (rxd_edge && !(s_q.pl_fm && s_q.pl_odd)) begin
                    // resync on edges; fm corrects on every other cell
                    s_d.pl_cnt = '0;
                    s_d.pl_seen = 1'b1;
                end else if (pl_tick) begin
                    s_d.pl_cnt = (s_q.pl_cnt == div - 6'h01) ? 6'h00 : s_q.pl_cnt + 6'h01;
                    // sampling edge at half cell: 16 then 48 in nrzi
                    if (s_q.pl_cnt == half - 6'h01)
                        s_d.pl_out = 1'b1;
                    if (s_q.pl_cnt == div - 6'h01) begin
                        s_d.pl_out = 1'b0;
                        s_d.pl_odd = !s_q.pl_odd;
                        if (s_q.pl_fm && !s_q.pl_odd) begin
                            if (!s_q.pl_seen) begin
                                s_d.miss1 = 1'b1;
                                if (s_q.miss1) begin
                                    s_d.miss2 = 1'b1;
                                    s_d.pl_st = PLRG_PL_SEARCH;
                                end
                            end
                            s_d.pl_seen = 1'b0;
                        end
                    end
                end
            end
            default: s_d.pl_st = PLRG_PL_OFF;
        endcase
        ////////////////////////////////////////////////////////////////////////
        // rate generator: down counter, output toggles on reload
        rg_tick = s_q.misc[PLRG_B_RGSRC] ? 1'b1 : pin_rise;
        s_d.rg_zero = 1'b0;
        if (!s_q.misc[PLRG_B_RGEN]) begin
            s_d.rg_lag = PLRG_RG_LAG;
            s_d.rg_cnt = s_q.tc;
        end else if (rg_tick) begin
            if (s_q.rg_lag != 2'h0)
                s_d.rg_lag = s_q.rg_lag - 2'h1;
            if (s_q.rg_cnt == 16'h0000) begin
                s_d.rg_cnt = s_q.tc;
                s_d.rg_zero = 1'b1;
                if (s_q.rg_lag == 2'h0)
                    s_d.rg_out = !s_q.rg_out;
            end else begin
                s_d.rg_cnt = s_q.rg_cnt - 16'h0001;
            end
        end
        ////////////////////////////////////////////////////////////////////////
        // event sources: only fresh changes count after enable
        ev_now = {chan.brk_abort, chan.underrun, s_q.pin_s2[1],
                  chan.sync_mode ? chan.hunt : s_q.ev_s2[2], s_q.pin_s2[0], s_q.rg_zero};
        s_d.ev_s1 = {5'h00, pins.sync_n} << 2;
        s_d.ev_s2 = s_q.ev_s1;
        s_d.ev_d = ev_now;
        ev_chg = (ev_now ^ s_q.ev_d) & ev_en;
        fire = chan.group_ie && (ev_chg != 6'h00);
        if (fire)
            s_d.ext_pend = 1'b1;
        ////////////////////////////////////////////////////////////////////////
        // request pin; stays active until internal transfer done
        if (s_q.misc[PLRG_B_REQSEL]) begin
            if (chan.strobe_done)
                s_d.req_hold = PLRG_REQ_HOLD;
            else if (s_q.req_hold != 3'h0)
                s_d.req_hold = s_q.req_hold - 3'h1;
            if ((chan.tx_empty || (chan.sync_mode && chan.crc_sent)) && s_q.req_hold == 3'h0)
                s_d.req_n = 1'b0;
            else if (s_q.req_hold == 3'h1)
                s_d.req_n = 1'b1;
        end else begin
            s_d.req_hold = 3'h0;
            s_d.req_n = !chan.dtr_bit;
        end
        ////////////////////////////////////////////////////////////////////////
        // register writes; loop commands are one-shot
        if (wr && s_q.rdy && hit(paddr, PLRG_ADDR_MISC)) begin
            s_d.misc = pwdata[7:0];
            case (cmd)
                PLRG_CMD_NULL: s_d.pl_st = s_q.pl_st;
                PLRG_CMD_SEARCH: begin
                    s_d.pl_st = PLRG_PL_SEARCH;
                    s_d.miss1 = 1'b0;
                    s_d.miss2 = 1'b0;
                end
                PLRG_CMD_RSTMISS, PLRG_CMD_DISABLE: begin
                    s_d.pl_st = PLRG_PL_OFF;
                    s_d.miss1 = 1'b0;
                    s_d.miss2 = 1'b0;
                end
                PLRG_CMD_SRC_RG: s_d.pl_src_rg = 1'b1;
                PLRG_CMD_SRC_PIN: s_d.pl_src_rg = 1'b0;
                PLRG_CMD_FM: s_d.pl_fm = 1'b1;
                PLRG_CMD_NRZI: s_d.pl_fm = 1'b0;
                default: s_d.pl_st = s_q.pl_st;
            endcase
        end
        if (wr && s_q.rdy && hit(paddr, PLRG_ADDR_EVT))
            s_d.evt = pwdata[7:0];
        if (wr && s_q.rdy && hit(paddr, PLRG_ADDR_TC))
            s_d.tc = pwdata[15:0];
        if (!wr && acc && hit(paddr, PLRG_ADDR_STAT) && !fire)
            s_d.ext_pend = 1'b0;
        // channel reset: misc and event registers and loop mode as after hardware reset, except rate bits; time constant kept
        if (chan_reset) begin
            s_d.misc = PLRG_MISC_RST | {6'h00, s_q.misc[PLRG_B_RGSRC:PLRG_B_RGEN]};
            s_d.evt = PLRG_EVT_RST;
            s_d.pl_st = PLRG_PL_OFF;
            s_d.pl_src_rg = 1'b0;
            s_d.pl_fm = 1'b0;
            s_d.miss1 = 1'b0;
            s_d.miss2 = 1'b0;
        end
        ////////////////////////////////////////////////////////////////////////
        // data paths and outputs
        s_d.o.txd = s_q.misc[PLRG_B_ECHO] ? s_q.pin_s2[2] : chan.tx_data;
        s_d.o.rx_in = (s_q.misc[PLRG_B_LOOPBK] && !s_q.misc[PLRG_B_ECHO]) ? chan.tx_data : s_q.pin_s2[2];
        s_d.o.cts_gate = !s_q.pin_s2[1] || s_q.misc[PLRG_B_LOOPBK] || s_q.misc[PLRG_B_ECHO];
        s_d.o.dcd_gate = !s_q.pin_s2[0] || s_q.misc[PLRG_B_LOOPBK];
        s_d.o.tx_visible = !s_q.misc[PLRG_B_ECHO];
        s_d.o.ready_req_n = s_q.req_n;
        s_d.o.phase_loop_clk = s_q.pl_out;
        s_d.o.rg_out = s_q.rg_out;
        s_d.o.rg_zero = s_q.rg_zero && s_q.evt[PLRG_E_ZC];
        s_d.o.ext_irq = s_q.ext_pend && chan.group_ie;
        s_d.o.one_missing = s_q.miss1;
        s_d.o.two_missing = s_q.miss2;
        s_d.o.fstat_en = s_q.evt[PLRG_E_FSTAT] && chan.sdlc_mode;
        s_d.o.ext_opt_en = s_q.evt[PLRG_E_ENH];
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.misc <= PLRG_MISC_RST;
            s_q.evt <= PLRG_EVT_RST;
            s_q.tc <= PLRG_TC_RST;
            s_q.pl_st <= PLRG_PL_OFF;
            s_q.pl_out <= 1'b1;
            s_q.rg_lag <= PLRG_RG_LAG;
            s_q.req_n <= 1'b1;
            s_q.o.ready_req_n <= 1'b1;
            s_q.o.tx_visible <= 1'b1;
            s_q.o.phase_loop_clk <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.rdata;
    assign pready = s_q.rdy;
    assign pslverr = s_q.err;
    assign outs = s_q.o;
endmodule

// file: src/plrg_pkg.sv
// package: constants and carriers of the misc control block
//
// Behaviour
// - reset disables loop, clears missing latches, picks clock pin source, NRZI.
// - command 000 leaves loop state unchanged.
// - command 001 enables loop, enters search, clears both missing latches.
// - NRZI search holds output high; first edge is a data edge.
// - NRZI loop clock 32x; samples at 16 and 48 clocks after first edge.
// - FM loop clock 16x; output low in search; first edge is clock edge.
// - FM missing edge sets one-missing; two misses set two-missing, re-search.
// - commands 010 and 011 disable loop, clear latches, hold search; here the loop goes to the off state, not search.
// - command 100 selects rate generator output as loop clock.
// - command 101 selects clock pin or crystal; reset default.
// - command 110 selects FM operation.
// - command 111 selects NRZI operation; reset default.
// - local loopback sends tx data to receiver and pin; cts/dcd enables ignored.
// - auto echo drives tx pin from rx pin; tx data hidden; cts ignored.
// - request select clear: pin is inverted ready bit; set: low on tx empty/crc.
// - request stays active until transfer done, four to five clocks after strobe.
// - rate source bit 0 picks pin or crystal, 1 host clock; reset 0.
// - rate enable starts counting, output lags two counts; clear stops at once.
// - source enables act only with group enable; only new conditions interrupt.
// - break, underrun, cts, dcd enables set by reset; zero count cleared.
// - sync/hunt enable: sync pin in async, hunt in sync; set by reset.
// - frame status enable only in sdlc; enhancement enable opens extended options.
package plrg_pkg;
    localparam logic [11:0] PLRG_ADDR_MISC = 12'h000;
    localparam logic [11:0] PLRG_ADDR_EVT = 12'h004;
    localparam logic [11:0] PLRG_ADDR_TC = 12'h008;
    localparam logic [11:0] PLRG_ADDR_STAT = 12'h00C;
    localparam logic [7:0] PLRG_MISC_RST = 8'h00;
    localparam logic [7:0] PLRG_EVT_RST = 8'hF8;
    localparam logic [15:0] PLRG_TC_RST = 16'h0004;
    localparam int PLRG_B_LOOPBK = 4;
    localparam int PLRG_B_ECHO = 3;
    localparam int PLRG_B_REQSEL = 2;
    localparam int PLRG_B_RGSRC = 1;
    localparam int PLRG_B_RGEN = 0;
    localparam int PLRG_E_BRK = 7;
    localparam int PLRG_E_UND = 6;
    localparam int PLRG_E_CTS = 5;
    localparam int PLRG_E_SYNC = 4;
    localparam int PLRG_E_DCD = 3;
    localparam int PLRG_E_FSTAT = 2;
    localparam int PLRG_E_ZC = 1;
    localparam int PLRG_E_ENH = 0;
    localparam logic [5:0] PLRG_NRZI_DIV = 6'h20;
    localparam logic [5:0] PLRG_NRZI_HALF = 6'h10;
    localparam logic [5:0] PLRG_FM_DIV = 6'h10;
    localparam logic [5:0] PLRG_FM_HALF = 6'h08;
    localparam logic [1:0] PLRG_RG_LAG = 2'h2;
    localparam int PLRG_REQ_CLKS = 4;
    localparam logic [2:0] PLRG_REQ_HOLD = 3'(PLRG_REQ_CLKS);
    typedef enum logic [2:0] {
        PLRG_CMD_NULL = 3'b000,
        PLRG_CMD_SEARCH = 3'b001,
        PLRG_CMD_RSTMISS = 3'b010,
        PLRG_CMD_DISABLE = 3'b011,
        PLRG_CMD_SRC_RG = 3'b100,
        PLRG_CMD_SRC_PIN = 3'b101,
        PLRG_CMD_FM = 3'b110,
        PLRG_CMD_NRZI = 3'b111
    } plrg_cmd_t;
    typedef enum logic [1:0] {
        PLRG_PL_OFF = 2'b00,
        PLRG_PL_SEARCH = 2'b01,
        PLRG_PL_TRACK = 2'b10
    } plrg_plst_t;
    typedef struct packed {
        logic rxd;
        logic cts_n;
        logic dcd_n;
        logic sync_n;
        logic clk_pin;
        logic xtal_clk;
    } plrg_pins_t;
    typedef struct packed {
        logic tx_data;
        logic tx_empty;
        logic crc_sent;
        logic sync_mode;
        logic sdlc_mode;
        logic hunt;
        logic brk_abort;
        logic underrun;
        logic dtr_bit;
        logic crystal_select;
        logic group_ie;
        logic strobe_done;
    } plrg_chan_t;
    typedef struct packed {
        logic txd;
        logic rx_in;
        logic cts_gate;
        logic dcd_gate;
        logic tx_visible;
        logic ready_req_n;
        logic phase_loop_clk;
        logic rg_out;
        logic rg_zero;
        logic ext_irq;
        logic one_missing;
        logic two_missing;
        logic fstat_en;
        logic ext_opt_en;
    } plrg_out_t;
endpackage

// file: tb/plrg_ctrl_checker.sv
// checker: port-level properties of the misc control block
`timescale 1ns/1ps
module plrg_ctrl_checker (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic chan_reset,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // line side
    input wire plrg_pkg::plrg_pins_t pins,
    input wire plrg_pkg::plrg_chan_t chan,
    input wire plrg_pkg::plrg_out_t outs
);
    import plrg_pkg::*;
    logic [15:0] mir_q;
    logic [15:0] mir_d;
    logic wr_hit;
    // mirror of both control bytes
    assign wr_hit = psel && penable && pready && pwrite;
    always_comb begin
        mir_d = mir_q;
        if (chan_reset) begin
            mir_d = {PLRG_EVT_RST, 6'h00, mir_q[1:0]};
        end else if (wr_hit && paddr == PLRG_ADDR_MISC) begin
            mir_d[7:0] = pwdata[7:0];
        end else if (wr_hit && paddr == PLRG_ADDR_EVT) begin
            mir_d[15:8] = pwdata[7:0];
        end
    end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mir_q <= {PLRG_EVT_RST, PLRG_MISC_RST};
        end else begin
            mir_q <= mir_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    reset_state_a: assert property ($rose(rstn) |-> outs.ready_req_n && !outs.one_missing && !outs.two_missing)
        else $error("outputs wrong after reset");
    latch_clear_a: assert property (wr_hit && paddr == PLRG_ADDR_MISC && pwdata[7:5] inside {[3'b001:3'b011]}
        |-> ##2 !outs.one_missing && !outs.two_missing) else $error("missing latches not cleared");
    loopback_path_a: assert property ((mir_q[4] && !mir_q[3] && $stable(chan.tx_data))[*3]
        |-> outs.txd == chan.tx_data && outs.rx_in == chan.tx_data && outs.cts_gate && outs.dcd_gate)
        else $error("loopback path wrong");
    echo_hides_a: assert property ((mir_q[3] && !mir_q[4])[*3] |-> !outs.tx_visible && outs.cts_gate)
        else $error("echo leaks tx data");
    req_dtr_a: assert property ((!mir_q[2] && $stable(chan.dtr_bit))[*3] |-> outs.ready_req_n == !chan.dtr_bit)
        else $error("request pin not inverted dtr");
    req_empty_a: assert property ((mir_q[2] && chan.tx_empty)[*3] |-> !outs.ready_req_n)
        else $error("request not active on empty");
    req_hold_a: assert property (chan.strobe_done && mir_q[2] && !outs.ready_req_n |=> !outs.ready_req_n [*3])
        else $error("request released early");
    rg_lag_a: assert property ($rose(mir_q[0]) |-> $stable(outs.rg_out) [*2])
        else $error("rate output moved too soon");
    rg_stop_a: assert property ((!mir_q[0])[*3] |-> $stable(outs.rg_out))
        else $error("rate output runs while disabled");
    enh_gate_a: assert property (($stable(mir_q[15:8]) && $stable(chan.sdlc_mode))[*2]
        |-> outs.fstat_en == (mir_q[10] && chan.sdlc_mode) && outs.ext_opt_en == mir_q[8])
        else $error("enhancement enables wrong");
    irq_group_a: assert property ((!chan.group_ie)[*2] |-> !outs.ext_irq)
        else $error("irq without group enable");
endmodule
bind plrg_ctrl plrg_ctrl_checker plrg_ctrl_checker_inst (.ref_clk(ref_clk), .rstn(rstn), .chan_reset(chan_reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .chan(chan), .outs(outs));

// file: tb/plrg_line_model.sv
// line model: far-end serial clock, data and modem lines
`timescale 1ns/1ps
module plrg_line_model (
    // controls from the bench
    input wire logic run_clk,
    input wire logic [3:0] lines,
    // pins into the block
    output plrg_pkg::plrg_pins_t pins
);
    import plrg_pkg::*;
    logic clk_q = 1'b0;
    logic xtal_q = 1'b0;
    // line clock parked low outside frames
    always #160 clk_q = run_clk ? !clk_q : 1'b0;
    // crystal runs free, phase unrelated to the host clock
    always #103 xtal_q = !xtal_q;
    assign pins = '{rxd: lines[0], cts_n: lines[1], dcd_n: lines[2], sync_n: lines[3],
        clk_pin: clk_q, xtal_clk: xtal_q};
endmodule

// file: tb/testbench.sv
// testbench: directed and random checks of the misc control block
`timescale 1ns/1ps
module testbench;
    import plrg_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic chan_reset = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic last_err;
    plrg_pins_t pins;
    plrg_chan_t chan = '0;
    plrg_out_t outs;
    logic run_clk = 1'b0;
    logic [3:0] lines = 4'hE;
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    integer seed = 32'h0000_7cb8;
    plrg_ctrl plrg_ctrl_inst (.ref_clk(ref_clk), .rstn(rstn), .chan_reset(chan_reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pins(pins), .chan(chan), .outs(outs));
    plrg_line_model plrg_line_model_inst (.run_clk(run_clk), .lines(lines), .pins(pins));
    always #12.5 ref_clk = !ref_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            miscompares++;
            report_and_stop;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        apb(1'b1, a, {24'h00_0000, d}, r);
    endtask
    task automatic flip(input int i);
        case (i)
            0: chan.brk_abort <= !chan.brk_abort;
            1: chan.underrun <= !chan.underrun;
            2: lines[1] <= !lines[1];
            3: lines[3] <= !lines[3];
            4: lines[2] <= !lines[2];
            default: chan.hunt <= !chan.hunt;
        endcase
    endtask
    // toggles of the rate output seen over k cycles
    task automatic count_tog(input int k, output int n);
        logic b;
        n = 0;
        b = outs.rg_out;
        repeat (k) begin
            @(posedge ref_clk);
            if (outs.rg_out !== b) n++;
            b = outs.rg_out;
        end
    endtask
    // status byte after a loop command; bits 1:0 masked
    function automatic logic [7:0] next_stat(input logic [2:0] c, input logic [7:0] s);
        case (c)
            3'b001: s = {PLRG_PL_SEARCH, s[5:4], 4'h0};
            3'b010, 3'b011: s = {PLRG_PL_OFF, s[5:4], 4'h0};
            3'b100: s[4] = 1'b1;
            3'b101: s[4] = 1'b0;
            3'b110: s[5] = 1'b1;
            3'b111: s[5] = 1'b0;
            default: s = s;
        endcase
        return s;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        logic [7:0] es;
        logic [2:0] cmds [10];
        logic b;
        int n;
        cmds = '{3'b001, 3'b000, 3'b100, 3'b000, 3'b101, 3'b110, 3'b111, 3'b010, 3'b001, 3'b011};
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        chk({outs.ready_req_n, outs.phase_loop_clk, outs.tx_visible, outs.one_missing,
             outs.two_missing}, 5'h1C);
        apb(1'b0, PLRG_ADDR_STAT, 32'h0, r);
        chk(r & 32'h0000_00FC, 32'h0);
        apb(1'b0, 12'h010, 32'h0, r);
        chk({last_err, r[30:0]}, 32'h8000_0000);
        es = 8'h00;
        foreach (cmds[i]) begin
            wr(PLRG_ADDR_MISC, {cmds[i], 5'h00});
            es = next_stat(cmds[i], es);
            apb(1'b0, PLRG_ADDR_STAT, 32'h0, r);
            chk(r & 32'h0000_00FC, es);
            if (es[7:6] == PLRG_PL_SEARCH) chk(outs.phase_loop_clk, !es[5]);
        end
        // one edge in fm search, then silence: misses must pile up
        wr(PLRG_ADDR_MISC, 8'hC0);
        wr(PLRG_ADDR_MISC, 8'h20);
        run_clk <= 1'b1;
        repeat (40) @(posedge ref_clk);
        lines[0] <= 1'b1;
        n = 0;
        while (outs.two_missing !== 1'b1 && n < 4000) begin
            n++;
            @(posedge ref_clk);
        end
        chk({outs.one_missing, outs.two_missing}, 2'b11);
        apb(1'b0, PLRG_ADDR_STAT, 32'h0, r);
        chk(r[7:6], PLRG_PL_SEARCH);
        wr(PLRG_ADDR_MISC, 8'h20);
        repeat (3) @(posedge ref_clk);
        chk({outs.one_missing, outs.two_missing}, 2'b00);
        run_clk <= 1'b0;
        wr(PLRG_ADDR_MISC, 8'h60);
        wr(PLRG_ADDR_MISC, 8'hE0);
        wr(PLRG_ADDR_MISC, 8'h10);
        repeat (8) begin
            b = 1'($random(seed));
            chan.tx_data <= b;
            repeat (4) @(posedge ref_clk);
            chk({outs.txd, outs.rx_in, outs.cts_gate, outs.dcd_gate}, {b, b, 2'b11});
        end
        wr(PLRG_ADDR_MISC, 8'h08);
        repeat (8) begin
            b = 1'($random(seed));
            lines[0] <= b;
            chan.tx_data <= !b;
            repeat (5) @(posedge ref_clk);
            chk({outs.txd, outs.rx_in, outs.tx_visible, outs.cts_gate}, {b, b, 2'b01});
        end
        wr(PLRG_ADDR_MISC, 8'h00);
        repeat (6) begin
            b = 1'($random(seed));
            chan.dtr_bit <= b;
            repeat (3) @(posedge ref_clk);
            chk({outs.ready_req_n, outs.tx_visible}, {!b, 1'b1});
        end
        chan.tx_empty <= 1'b1;
        wr(PLRG_ADDR_MISC, 8'h04);
        repeat (3) @(posedge ref_clk);
        chk(outs.ready_req_n, 1'b0);
        chan.strobe_done <= 1'b1;
        chan.tx_empty <= 1'b0;
        @(posedge ref_clk);
        chan.strobe_done <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk(outs.ready_req_n, 1'b0);
        repeat (5) @(posedge ref_clk);
        chk(outs.ready_req_n, 1'b1);
        // mid-run channel reset
        chan.dtr_bit <= 1'b0;
        chan.tx_empty <= 1'b1;
        wr(PLRG_ADDR_MISC, 8'hC4);
        chan_reset <= 1'b1;
        @(posedge ref_clk);
        chan_reset <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk(outs.ready_req_n, 1'b1);
        apb(1'b0, PLRG_ADDR_STAT, 32'h0, r);
        chk(r & 32'h0000_00FC, 32'h0);
        wr(PLRG_ADDR_TC, 8'h01);
        wr(PLRG_ADDR_EVT, 8'h02);
        chan.group_ie <= 1'b1;
        wr(PLRG_ADDR_MISC, 8'h03);
        count_tog(100, n);
        chk(n != 0, 1'b1);
        chk(outs.ext_irq, 1'b1);
        b = outs.rg_zero;
        @(posedge ref_clk);
        chk(outs.rg_zero, !b);
        wr(PLRG_ADDR_MISC, 8'h02);
        repeat (2) @(posedge ref_clk);
        count_tog(50, n);
        chk(n, 0);
        wr(PLRG_ADDR_MISC, 8'h01);
        count_tog(100, n);
        chk(n, 0);
        wr(PLRG_ADDR_MISC, 8'h00);
        for (int i = 0; i < 6; i++) begin
            chan.sync_mode <= (i == 5);
            wr(PLRG_ADDR_EVT, 8'h00);
            flip(i);
            repeat (6) @(posedge ref_clk);
            apb(1'b0, PLRG_ADDR_STAT, 32'h0, r);
            wr(PLRG_ADDR_EVT, 8'(8'h01 << (i < 5 ? 7 - i : 4)));
            repeat (6) @(posedge ref_clk);
            chk(outs.ext_irq, 1'b0);
            flip(i);
            if (i == 1) begin
                repeat (6) @(posedge ref_clk);
                flip(i);
            end
            repeat (6) @(posedge ref_clk);
            chk(outs.ext_irq, 1'b1);
            apb(1'b0, PLRG_ADDR_STAT, 32'h0, r);
            repeat (2) @(posedge ref_clk);
            chk(outs.ext_irq, 1'b0);
        end
        chan.group_ie <= 1'b0;
        wr(PLRG_ADDR_EVT, 8'hF8);
        flip(0);
        repeat (6) @(posedge ref_clk);
        chk(outs.ext_irq, 1'b0);
        wr(PLRG_ADDR_EVT, 8'h05);
        repeat (3) @(posedge ref_clk);
        chk({outs.fstat_en, outs.ext_opt_en}, 2'b01);
        chan.sdlc_mode <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk({outs.fstat_en, outs.ext_opt_en}, 2'b11);
        report_and_stop;
    end
endmodule
